/* File: core/olcc_top.sv */
// Operation
// RULE1 - Level code is signed two's complement
// RULE2 - Sign at bit 25, bits 31:26 copy
// RULE3 - Code zero gives midscale, zero output
// RULE4 - Output scales linearly with signed code
// RULE5 - Upper limit field caps code maximum
// RULE6 - Lower limit field sets code minimum
// RULE7 - Duty select picks PWM duty window
// RULE8 - Duty select leaves differential relation unchanged
// RULE9 - Pulses below 50 ns are skipped
// RULE10 - Host avoids extreme output levels
// RULE11 - Host writes level code over serial
// RULE12 - Host picks window suited to frequency
// RULE13 - Host holds code 160 us after enable
// RULE14 - Signed compare, out-of-range code replaced
// RULE15 - Disagreeing upper bits are ignored
`timescale 1ns/10ps
`default_nettype none

module olcc_top
    import olcc_pkg::*;
#(
    parameter int PERIOD = OLCC_PERIOD_CYC
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic code_we_i,
    input wire logic [31:0] code_wdata_i,
    input wire logic upper_we_i,
    input wire logic [3:0] upper_wdata_i,
    input wire logic lower_we_i,
    input wire logic [3:0] lower_wdata_i,
    input wire logic duty_we_i,
    input wire logic [1:0] duty_wdata_i,
    input wire logic switching_permit_i,
    output logic [31:0] output_level_code_o,
    output logic [3:0] upper_code_limit_o,
    output logic [3:0] lower_code_limit_o,
    output logic [1:0] duty_range_select_o,
    output logic signed [25:0] setpoint_o,
    output logic signed [29:0] diff_level_o,
    output logic [6:0] duty_min_pct_o,
    output logic [6:0] duty_max_pct_o,
    output logic switched_output_terminal_o,
    output logic signed [29:0] linear_output_terminal_o,
    output logic clamp_active_o,
    output logic pulse_skip_o
);

    // ----------------------------------------------------------------
    // Overview
    // ----------------------------------------------------------------
    // Host writes land in the register set on the strobe edge
    // The clamp works on the stored code, its result registered
    // Differential level is the clamped code times sixteen
    // Linear terminal follows the clamped code times eight
    // PWM duty spans the selected window over the full code range while PERIOD times span is at most 16384
    // Pulses shorter than the minimum are skipped, never shortened
    //
    // Register set
    //   output_level_code  32 bits, bits 31:26 copy bit 25
    //   upper_code_limit   4 bits, maximum code (N+1)*2^20-1
    //   lower_code_limit   4 bits, minimum code N*2^20-2^24
    //   duty_range_select  2 bits, 20/80, 15/85, 10/90 percent
    //
    // Timing in edges after the strobe is sampled
    //   register readback    1
    //   setpoint and levels  2
    //   clamp flag, window   2
    //   PWM duty             first period start after that
    //   writes to several registers in one cycle all land
    //
    // Reset
    //   code zero, widest limits, 20 to 80 percent window
    //   derived levels and window read zero until the first edge
    //   switched terminal low while switching is not permitted
    //
    // Limitations
    //   linear terminal gain does not follow the duty select
    //   PERIOD is a model period; short periods coarsen the duty
    //   duty rounds down, the window ceiling is never quite reached
    //   no read strobe; readback ports always show the registers

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // One register image holds all state outside the PWM, whose counter and outputs sit in u_pwm
    typedef struct packed {
        // Host registers
        olcc_cfg_t cfg;
        // Clamped code and the levels derived from it
        logic signed [25:0] setpoint;
        logic signed [29:0] diff;
        logic signed [29:0] lin;
        // Window and duty handed to the PWM
        olcc_window_t win;
        logic [15:0] duty_cyc;
        // Clamp engaged
        logic clamp;
    } olcc_top_state_t;

    olcc_top_state_t s_reg;
    olcc_top_state_t s_next;

    // Clamp results
    logic signed [25:0] clamped;
    logic hit_upper;
    logic hit_lower;

    // PWM results
    logic pwm;
    logic skip;

    // Window and duty mapping
    olcc_window_t win;
    logic [6:0] span;
    logic signed [39:0] code_off;
    logic signed [39:0] per_w;
    logic signed [39:0] min_w;
    logic signed [39:0] span_w;
    logic signed [39:0] floor_cyc;
    logic signed [39:0] share_cyc;
    logic signed [39:0] duty_wide;

    // Written code with the sign copied upward
    logic [31:0] code_ext;

    // ----------------------------------------------------------------
    // Clamp and PWM
    // ----------------------------------------------------------------
    // Signed clamp against both limits
    olcc_clamp u_clamp (
        .code_i(s_reg.cfg.code),
        .upper_i(s_reg.cfg.upper),
        .lower_i(s_reg.cfg.lower),
        .clamped_o(clamped),
        .hit_upper_o(hit_upper),
        .hit_lower_o(hit_lower)
    );

    // Switched terminal PWM over one model period
    olcc_pwm #(
        .PERIOD(PERIOD),
        .MIN_PULSE(OLCC_MIN_PULSE_CYC)
    ) u_pwm (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .enable_i(switching_permit_i),
        .duty_cyc_i(s_reg.duty_cyc),
        .pwm_o(pwm),
        .skip_o(skip)
    );

    // ----------------------------------------------------------------
    // Duty window
    // ----------------------------------------------------------------

    // Window floor from the select field, ceiling mirrors it
    always_comb begin
        case (olcc_duty_t'(s_reg.cfg.duty))
            OLCC_DUTY_20_80: begin
                win.min_pct = OLCC_MIN_PCT_20; // RULE7
            end
            OLCC_DUTY_15_85: begin
                win.min_pct = OLCC_MIN_PCT_15; // RULE7
            end
            // Both upper select values give the widest window
            OLCC_DUTY_10_90, OLCC_DUTY_10_90B: begin
                win.min_pct = OLCC_MIN_PCT_10; // RULE7
            end
            default: begin
                win.min_pct = OLCC_MIN_PCT_10;
            end
        endcase
        // Symmetric window about half duty
        win.max_pct = OLCC_FULL_PCT - win.min_pct;
        // Usable span between floor and ceiling
        span = win.max_pct - win.min_pct;
    end

    // ----------------------------------------------------------------
    // Duty mapping
    // ----------------------------------------------------------------

    // Code shifted up by half the range, zero at the most negative code
    assign code_off = 40'(clamped + 26'sh100_0000);

    // Operands widened to 40 bits; the code share product overflows once PERIOD times span exceeds 16384
    assign per_w = 40'(signed'(PERIOD));
    assign min_w = 40'(signed'({1'b0, win.min_pct}));
    assign span_w = 40'(signed'({1'b0, span}));

    // Window floor in cycles
    assign floor_cyc = per_w * min_w / 40'sh64;

    // Share of the window span set by the code, midscale at centre
    assign share_cyc = per_w * span_w * code_off / (40'sh64 * 40'sh200_0000);

    // Full signed range maps onto the window only
    assign duty_wide = floor_cyc + share_cyc; // RULE8

    // ----------------------------------------------------------------
    // Sign copy of the written code
    // ----------------------------------------------------------------

    // Bits above the sign take the sign, bits below pass unchanged
    for (genvar g = 0; g < 32; g++) begin : g_code_bit
        if (g > OLCC_SIGN_POS) begin : g_copy
            assign code_ext[g] = code_wdata_i[OLCC_SIGN_POS]; // RULE2
        end else begin : g_keep
            assign code_ext[g] = code_wdata_i[g];
        end
    end

    // ----------------------------------------------------------------
    // Register writes and derived levels
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;

        // Level code, bits 31:26 rebuilt from bit 25
        if (code_we_i) begin
            s_next.cfg.code = code_ext; // RULE2
        end

        // Upper limit field, used by the next clamp
        if (upper_we_i) begin
            s_next.cfg.upper = upper_wdata_i;
        end

        // Lower limit field, used by the next clamp
        if (lower_we_i) begin
            s_next.cfg.lower = lower_wdata_i;
        end

        // Duty select, window and duty follow one edge later
        if (duty_we_i) begin
            s_next.cfg.duty = duty_wdata_i;
        end

        // Clamped code; zero code gives the midscale setpoint
        s_next.setpoint = clamped; // RULE3

        // Differential level is 16 steps per code, independent of duty select
        s_next.diff = 30'(clamped) <<< 4; // RULE4 RULE8

        // Linear terminal at half the differential gain
        s_next.lin = 30'(clamped) <<< 3; // RULE8

        // Window and duty for the PWM
        s_next.win = win;
        s_next.duty_cyc = duty_wide[15:0];

        // Flag set while either limit replaces the code
        s_next.clamp = hit_upper | hit_lower; // RULE14
    end

    // Register image; reset loads the package values
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // Host registers
            s_reg.cfg.code <= OLCC_CODE_RST;
            s_reg.cfg.upper <= OLCC_UPPER_RST;
            s_reg.cfg.lower <= OLCC_LOWER_RST;
            s_reg.cfg.duty <= OLCC_DUTY_RST;

            // Derived state cleared
            s_reg.setpoint <= '0;
            s_reg.diff <= '0;
            s_reg.lin <= '0;
            s_reg.win <= '0;
            s_reg.duty_cyc <= '0;
            s_reg.clamp <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Register readback
    assign output_level_code_o = s_reg.cfg.code;
    assign upper_code_limit_o = s_reg.cfg.upper;
    assign lower_code_limit_o = s_reg.cfg.lower;
    assign duty_range_select_o = s_reg.cfg.duty;

    // Derived levels, all from the same clamped code
    assign setpoint_o = s_reg.setpoint;
    assign diff_level_o = s_reg.diff;
    assign linear_output_terminal_o = s_reg.lin;
    assign clamp_active_o = s_reg.clamp;

    // Duty window in percent
    assign duty_min_pct_o = s_reg.win.min_pct;
    assign duty_max_pct_o = s_reg.win.max_pct;

    // Switched terminal and skip flag straight from the PWM flops
    assign switched_output_terminal_o = pwm;
    assign pulse_skip_o = skip;

endmodule : olcc_top

`default_nettype wire

/* File: core/olcc_pkg.sv */
`default_nettype none

package olcc_pkg;

    // ----------------------------------------------------------------
    // Widths and positions
    // ----------------------------------------------------------------
    localparam int OLCC_CODE_W = 26;
    localparam int OLCC_SIGN_POS = 25;
    localparam int OLCC_LIMIT_STEP_POS = 20;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] OLCC_CODE_RST = 32'h0000_0000;
    localparam logic [3:0] OLCC_UPPER_RST = 4'hF;
    localparam logic [3:0] OLCC_LOWER_RST = 4'h0;
    localparam logic [1:0] OLCC_DUTY_RST = 2'h0;

    // ----------------------------------------------------------------
    // Limit bases
    // ----------------------------------------------------------------
    localparam logic [25:0] OLCC_UPPER_BASE = 26'h00F_FFFF;
    localparam logic [25:0] OLCC_LOWER_BASE = 26'h300_0000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int OLCC_CLK_MHZ = 200;
    localparam int OLCC_MIN_PULSE_NS = 50;
    localparam int OLCC_MIN_PULSE_CYC = (OLCC_MIN_PULSE_NS * OLCC_CLK_MHZ + 999) / 1000;
    localparam int OLCC_PERIOD_CYC = 1000;

    // ----------------------------------------------------------------
    // Duty windows in percent
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OLCC_DUTY_20_80 = 2'b00,
        OLCC_DUTY_15_85 = 2'b01,
        OLCC_DUTY_10_90 = 2'b10,
        OLCC_DUTY_10_90B = 2'b11
    } olcc_duty_t;

    localparam logic [6:0] OLCC_MIN_PCT_20 = 7'h14;
    localparam logic [6:0] OLCC_MIN_PCT_15 = 7'h0F;
    localparam logic [6:0] OLCC_MIN_PCT_10 = 7'h0A;
    localparam logic [6:0] OLCC_FULL_PCT = 7'h64;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] code;
        logic [3:0] upper;
        logic [3:0] lower;
        logic [1:0] duty;
    } olcc_cfg_t;

    typedef struct packed {
        logic [6:0] min_pct;
        logic [6:0] max_pct;
    } olcc_window_t;

endpackage : olcc_pkg

`default_nettype wire

/* File: core/olcc_clamp.sv */
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------------
// Signed clamp of the output level code
// --------------------------------------------------------------------
module olcc_clamp
    import olcc_pkg::*;
(
    input wire logic [31:0] code_i,
    input wire logic [3:0] upper_i,
    input wire logic [3:0] lower_i,
    output logic signed [25:0] clamped_o,
    output logic hit_upper_o,
    output logic hit_lower_o
);

    logic signed [25:0] code_s;
    logic signed [25:0] max_s;
    logic signed [25:0] min_s;

    // Bit 25 is the sign, upper bits ignored
    assign code_s = signed'(code_i[25:0]); // RULE15
    // Limits stepped by 2^20 per field unit
    assign max_s = signed'(OLCC_UPPER_BASE + {2'h0, upper_i, 20'h0_0000}); // RULE5
    assign min_s = signed'(OLCC_LOWER_BASE + {2'h0, lower_i, 20'h0_0000}); // RULE6

    // Signed compare against both limits
    always_comb begin
        hit_upper_o = code_s > max_s; // RULE14
        hit_lower_o = code_s < min_s; // RULE14
        if (hit_upper_o) begin
            clamped_o = max_s;
        end else if (hit_lower_o) begin
            clamped_o = min_s;
        end else begin
            clamped_o = code_s; // RULE1
        end
    end

endmodule : olcc_clamp

`default_nettype wire

/* File: core/olcc_pwm.sv */
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------------
// PWM for the switched terminal with pulse skipping
// --------------------------------------------------------------------
module olcc_pwm
    import olcc_pkg::*;
#(
    parameter int PERIOD = OLCC_PERIOD_CYC,
    parameter int MIN_PULSE = OLCC_MIN_PULSE_CYC
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic enable_i,
    input wire logic [15:0] duty_cyc_i,
    output logic pwm_o,
    output logic skip_o
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] duty;
        logic pwm;
        logic skip;
    } olcc_pwm_state_t;

    olcc_pwm_state_t s_reg;
    olcc_pwm_state_t s_next;

    // Period counter, duty latched at period start, short pulses skipped
    always_comb begin
        s_next = s_reg;
        if (!enable_i) begin
            s_next = '0;
        end else begin
            if (s_reg.cnt == 16'(PERIOD - 1)) begin
                s_next.cnt = 16'h0000;
            end else begin
                s_next.cnt = s_reg.cnt + 16'h0001;
            end
            if (s_reg.cnt == 16'h0000) begin
                s_next.duty = duty_cyc_i;
            end
            s_next.skip = (s_next.duty < 16'(MIN_PULSE)) ||
                          (s_next.duty > 16'(PERIOD - MIN_PULSE)); // RULE9
            if (s_next.duty < 16'(MIN_PULSE)) begin
                s_next.pwm = 1'b0;
            end else if (s_next.duty > 16'(PERIOD - MIN_PULSE)) begin
                s_next.pwm = 1'b1;
            end else begin
                s_next.pwm = s_next.cnt < s_next.duty;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pwm_o = s_reg.pwm;
    assign skip_o = s_reg.skip;

endmodule : olcc_pwm

`default_nettype wire

/* File: verification/olcc_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Output checker
// ------------------------------
module olcc_top_asserts
    import olcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic code_we_i,
    input wire logic [31:0] code_wdata_i,
    input wire logic [31:0] output_level_code_o,
    input wire logic [3:0] upper_code_limit_o,
    input wire logic [3:0] lower_code_limit_o,
    input wire logic [1:0] duty_range_select_o,
    input wire logic signed [25:0] setpoint_o,
    input wire logic signed [29:0] diff_level_o,
    input wire logic signed [29:0] linear_output_terminal_o,
    input wire logic [6:0] duty_min_pct_o,
    input wire logic [6:0] duty_max_pct_o,
    input wire logic clamp_active_o
);
    logic live_reg;
    function automatic int hi_f(logic [3:0] n); return (int'(n) + 1) * 1048576 - 1; endfunction : hi_f
    function automatic int lo_f(logic [3:0] n); return int'(n) * 1048576 - 16777216; endfunction : lo_f
    function automatic logic [6:0] wm_f(logic [1:0] d); return d[1] ? 7'h0A : (d[0] ? 7'h0F : 7'h14); endfunction : wm_f

    // Limit, clamp flag and window checks are judged from the second edge after reset on; diff and lin from the first
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            live_reg <= 1'b0;
        end else begin
            live_reg <= 1'b1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_code_sext;
        code_we_i |=> output_level_code_o == {{6{$past(code_wdata_i[25])}}, $past(code_wdata_i[25:0])};
    endproperty
    a_code_sext: assert property (p_code_sext) else $error("code readback not sign copied");
    property p_sign_copy;
        output_level_code_o[31:26] == {6{output_level_code_o[25]}};
    endproperty
    a_sign_copy: assert property (p_sign_copy) else $error("upper code bits differ from sign");
    property p_upper;
        live_reg |-> int'(setpoint_o) <= hi_f($past(upper_code_limit_o));
    endproperty
    a_upper: assert property (p_upper) else $error("setpoint above upper limit");
    property p_lower;
        live_reg |-> int'(setpoint_o) >= lo_f($past(lower_code_limit_o));
    endproperty
    a_lower: assert property (p_lower) else $error("setpoint below lower limit");
    property p_flag;
        live_reg |-> clamp_active_o == (int'(setpoint_o) != int'($signed($past(output_level_code_o[25:0]))));
    endproperty
    a_flag: assert property (p_flag) else $error("clamp flag wrong");
    property p_diff;
        diff_level_o == {setpoint_o, 4'h0};
    endproperty
    a_diff: assert property (p_diff) else $error("differential level not sixteen times setpoint");
    property p_lin;
        linear_output_terminal_o == {setpoint_o[25], setpoint_o, 3'h0};
    endproperty
    a_lin: assert property (p_lin) else $error("linear terminal not eight times setpoint");
    property p_window;
        live_reg |-> duty_min_pct_o == wm_f($past(duty_range_select_o))
            && duty_max_pct_o == 7'h64 - wm_f($past(duty_range_select_o));
    endproperty
    a_window: assert property (p_window) else $error("duty window wrong");
endmodule : olcc_top_asserts

bind olcc_top olcc_top_asserts u_olcc_top_asserts (.clk_i(clk_i), .rstn_i(rstn_i),
    .code_we_i(code_we_i), .code_wdata_i(code_wdata_i), .output_level_code_o(output_level_code_o),
    .upper_code_limit_o(upper_code_limit_o), .lower_code_limit_o(lower_code_limit_o),
    .duty_range_select_o(duty_range_select_o), .setpoint_o(setpoint_o), .diff_level_o(diff_level_o),
    .linear_output_terminal_o(linear_output_terminal_o), .duty_min_pct_o(duty_min_pct_o),
    .duty_max_pct_o(duty_max_pct_o), .clamp_active_o(clamp_active_o));
`default_nettype wire

/* File: verification/olcc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Host writing the registers
// ------------------------------
module olcc_host_model #(
    parameter int HOLD_CYC = 32000
)
(
    input wire logic clk_i,
    output logic code_we_i,
    output logic [31:0] code_wdata_i,
    output logic upper_we_i,
    output logic [3:0] upper_wdata_i,
    output logic lower_we_i,
    output logic [3:0] lower_wdata_i,
    output logic duty_we_i,
    output logic [1:0] duty_wdata_i,
    output logic switching_permit_i
);
    // Idle at time zero
    initial begin
        {code_we_i, upper_we_i, lower_we_i, duty_we_i, switching_permit_i} = 5'h00;
        {code_wdata_i, upper_wdata_i, lower_wdata_i, duty_wdata_i} = 42'h0;
    end

    // One write, strobe held over one edge, data scrambled after
    task automatic wr(input logic [1:0] sel, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        {code_we_i, upper_we_i, lower_we_i, duty_we_i} = 4'h8 >> sel;
        {code_wdata_i, upper_wdata_i, lower_wdata_i, duty_wdata_i} = {d, d[3:0], d[3:0], d[1:0]};
        @(posedge clk_i);
        #1;
        {code_we_i, upper_we_i, lower_we_i, duty_we_i} = 4'h0;
        {code_wdata_i, upper_wdata_i, lower_wdata_i, duty_wdata_i} = ~{d, d[3:0], d[3:0], d[1:0]};
    endtask : wr

    // Enable switching and keep the code still meanwhile
    task automatic permit();
        switching_permit_i = 1'b1;
        repeat (HOLD_CYC) @(posedge clk_i);
        #1;
    endtask : permit
endmodule : olcc_host_model
`default_nettype wire

/* File: verification/olcc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module olcc_top_tb import olcc_pkg::*;;
    localparam int PER = 40;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic code_we_i, upper_we_i, lower_we_i, duty_we_i, switching_permit_i;
    logic [31:0] code_wdata_i, output_level_code_o;
    logic [3:0] upper_wdata_i, lower_wdata_i, upper_code_limit_o, lower_code_limit_o;
    logic [1:0] duty_wdata_i, duty_range_select_o;
    logic signed [25:0] setpoint_o;
    logic signed [29:0] diff_level_o, linear_output_terminal_o;
    logic [6:0] duty_min_pct_o, duty_max_pct_o;
    logic switched_output_terminal_o, clamp_active_o, pulse_skip_o;
    int err_total = 0;
    int check_count = 0;

    // Clock
    always #2.5 clk_i = ~clk_i;

    olcc_host_model u_olcc_host_model (.*);
    olcc_top #(.PERIOD(PER)) u_olcc_top (.*);

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wt

    task automatic wr(input logic [1:0] sel, input logic [31:0] d);
        u_olcc_host_model.wr(sel, d);
        wt(2);
    endtask : wr

    // Readback, levels and clamp flag for code d, expected setpoint e; duty window not checked
    task automatic chk_out(input logic [31:0] d, input int e);
        chk("code", output_level_code_o, {{6{d[25]}}, d[25:0]});
        chk("setpoint", 32'(setpoint_o), 32'(e));
        chk("diff", 32'(diff_level_o), 32'(e * 16));
        chk("lin", 32'(linear_output_terminal_o), 32'(e * 8));
        chk("clamp", 32'(clamp_active_o), 32'(e != int'($signed(d[25:0]))));
    endtask : chk_out

    task automatic t_reset();
        wt(1);
        chk_out(32'h0, 0);
        chk("regs", {upper_code_limit_o, lower_code_limit_o, duty_range_select_o}, 32'h3C0);
        chk("wmin", 32'(duty_min_pct_o), 32'h14);
    endtask : t_reset

    // Sign handling and clamping at the default limits
    task automatic t_codes();
        logic [31:0] tb_l [8];
        int v;
        tb_l = '{32'h1, 32'h03FF_FFFF, 32'hFC00_0001, 32'h00FF_FFFF, 32'h0100_0000,
                 32'hFF00_0000, 32'h02FF_FFFF, 32'h0};
        foreach (tb_l[i]) begin
            wr(2'h0, tb_l[i]);
            v = $signed(tb_l[i][25:0]);
            v = (v > 16777215) ? 16777215 : ((v < -16777216) ? -16777216 : v);
            chk_out(tb_l[i], v);
        end
    endtask : t_codes

    // Every limit field value against codes beyond both ends
    task automatic t_limits();
        for (int n = 0; n < 16; n++) begin
            wr(2'h1, 32'(n));
            wr(2'h2, 32'(n));
            wr(2'h0, 32'h0100_0000);
            chk("limits", 32'({upper_code_limit_o, lower_code_limit_o}), 32'(n * 17));
            chk_out(32'h0100_0000, (n + 1) * 1048576 - 1);
            wr(2'h0, 32'hFEFF_FFFF);
            chk_out(32'hFEFF_FFFF, n * 1048576 - 16777216);
        end
        wr(2'h1, 32'hF);
        wr(2'h2, 32'h0);
    endtask : t_limits

    // Every duty select, differential level must not move
    task automatic t_duty();
        int mn;
        wr(2'h0, 32'h0012_3456);
        for (int d = 0; d < 4; d++) begin
            wr(2'h3, 32'(d));
            mn = (d == 0) ? 20 : ((d == 1) ? 15 : 10);
            chk("dsel", 32'(duty_range_select_o), 32'(d));
            chk("wmin", 32'(duty_min_pct_o), 32'(mn));
            chk("wmax", 32'(duty_max_pct_o), 32'(100 - mn));
            chk("diff", 32'(diff_level_o), 32'h0123_4560);
        end
        wr(2'h3, 32'h0);
        wr(2'h0, 32'h0);
    endtask : t_duty

    // Midscale switching, then an extreme level that forces skipping
    task automatic t_pwm();
        int cnt;
        cnt = 0;
        u_olcc_host_model.permit();
        repeat (2 * PER) begin
            wt(1);
            cnt += (switched_output_terminal_o === 1'b1) ? 1 : 0;
        end
        chk("pwm_mid", 32'(cnt > PER / 2 && cnt < 3 * PER / 2), 32'h1);
        chk("skip_mid", 32'(pulse_skip_o), 32'h0);
        wr(2'h0, 32'h00FF_FFFF);
        wt(3 * PER);
        chk("skip_max", 32'(pulse_skip_o), 32'h1);
    endtask : t_pwm

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        t_reset();
        t_codes();
        t_limits();
        t_duty();
        t_pwm();
        final_report();
    end

    // Watchdog
    initial begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        final_report();
    end
endmodule : olcc_top_tb
`default_nettype wire
